/* rtl/copro_glue_pkg.sv */
`default_nettype none
package copro_glue_pkg;
  // clock figure used to turn times into cycle counts
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  // least time an ISA cycle runs before the internal ready may end it
  localparam int unsigned ISA_MIN_CYCLE_NS = 30;
  // least time rounds up to whole clock cycles, never below one
  localparam int unsigned ISA_MIN_CYCLES_RAW =
    (ISA_MIN_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned ISA_MIN_CYCLES =
    (ISA_MIN_CYCLES_RAW < 1) ? 1 : ISA_MIN_CYCLES_RAW;
  localparam int unsigned WAIT_CNT_W = 4;
  localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_LAST = WAIT_CNT_W'(ISA_MIN_CYCLES - 1);
  localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_RESET = 4'h0;

  // positions of the pin inputs in the synchroniser bank
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned PIN_XFER_REQ = 0;
  localparam int unsigned PIN_BUSY_N = 1;
  localparam int unsigned PIN_ERR_N = 2;
  localparam int unsigned PIN_READY_N = 3;
  localparam int unsigned PIN_CHAN_READY = 4;
  localparam int unsigned PIN_ISA_CYCLE = 5;
  // value each synchroniser takes in reset: the inactive level of its pin
  localparam logic [PIN_COUNT-1:0] PIN_RESET_LEVEL = 6'h1e;

  // values of the outputs after reset
  localparam logic XFER_REQ_RESET = 1'h0;
  localparam logic BUSY_N_RESET = 1'h1;
  localparam logic ERR_N_RESET = 1'h1;
  localparam logic IRQ_RESET = 1'h0;
  localparam logic READY_N_RESET = 1'h1;
  localparam logic STATUS_ENABLE_RESET = 1'h0;
  localparam logic CHAN_READY_OE_RESET = 1'h0;
  localparam logic CHAN_READY_OUT_RESET = 1'h0;

  // internal ready sequencer for ISA and peripheral cycles
  typedef enum logic [1:0] {
    ISA_IDLE = 2'b00,
    ISA_WAIT = 2'b01,
    ISA_DONE = 2'b10
  } isa_state_t;
endpackage
`default_nettype wire

/* rtl/numeric_copro_glue.sv */
// Functional notes
// RULE1: while the coprocessor transfer request input is high the transfer request output to the host is high.
// RULE2: the coprocessor drops its transfer request once all operands have passed through its FIFO.
// RULE3: an active-high interrupt output, meant for interrupt line 13, signals a coprocessor interrupt.
// RULE4: the active-low coprocessor busy input yields an active-low busy output to the host.
// RULE5: the active-low coprocessor error input yields an active-low error output to the host.
// RULE6: the coprocessor asserts its active-low ready to end a coprocessor bus cycle.
// RULE7: an active-high status enable output selects the coprocessor, whose status pins float while it is low.
// RULE8: a low channel ready input inserts wait states in ISA cycles and takes part in forming the host ready.
// RULE9: during a coprocessor reset cycle the channel ready pin is turned into a driven output.
// RULE10: the host ready is the OR of the coprocessor ready and the internally made ready.
// RULE11: after system reset busy, error, transfer request and interrupt outputs stay inactive until inputs assert.
`timescale 1ns/100ps
`default_nettype none
module numeric_copro_glue (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_COPRO_XFER_REQ_IN,
  input wire logic I_COPRO_BUSY_IN_N,
  input wire logic I_COPRO_ERR_IN_N,
  input wire logic I_COPRO_READY_IN_N,
  input wire logic I_CHAN_READY_IN,
  input wire logic I_ISA_CYCLE,
  input wire logic I_COPRO_RESET_CYCLE,
  output logic O_HOST_XFER_REQ_OUT,
  output logic O_HOST_BUSY_OUT_N,
  output logic O_HOST_ERR_OUT_N,
  output logic O_COPRO_IRQ_OUT,
  output logic O_HOST_READY_OUT_N,
  output logic O_COPRO_STATUS_ENABLE,
  output logic O_CHAN_READY_OUT,
  output logic O_CHAN_READY_OE
);

  // raw pin bundle feeding the synchroniser bank
  wire [copro_glue_pkg::PIN_COUNT-1:0] pin_raw;
  logic [copro_glue_pkg::PIN_COUNT-1:0] sync_first;
  logic [copro_glue_pkg::PIN_COUNT-1:0] sync_second;
  logic reset_cycle_first;
  logic reset_cycle;
  copro_glue_pkg::isa_state_t isa_state;
  copro_glue_pkg::isa_state_t next_isa_state;
  logic [copro_glue_pkg::WAIT_CNT_W-1:0] wait_cnt;
  logic [copro_glue_pkg::WAIT_CNT_W-1:0] next_wait_cnt;

  // gather the pins so one generate loop synchronises them all;
  // the reset cycle request stays apart since it never needs masking
  assign pin_raw[copro_glue_pkg::PIN_XFER_REQ] = I_COPRO_XFER_REQ_IN;
  assign pin_raw[copro_glue_pkg::PIN_BUSY_N] = I_COPRO_BUSY_IN_N;
  assign pin_raw[copro_glue_pkg::PIN_ERR_N] = I_COPRO_ERR_IN_N;
  assign pin_raw[copro_glue_pkg::PIN_READY_N] = I_COPRO_READY_IN_N;
  assign pin_raw[copro_glue_pkg::PIN_CHAN_READY] = I_CHAN_READY_IN;
  assign pin_raw[copro_glue_pkg::PIN_ISA_CYCLE] = I_ISA_CYCLE;

  // two-flop synchroniser per pin; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < copro_glue_pkg::PIN_COUNT; g = g + 1)
    begin : g_sync
      always_ff @(posedge I_CLOCK)
      begin
        if (I_RESET)
        begin
          sync_first[g] <= copro_glue_pkg::PIN_RESET_LEVEL[g];
          sync_second[g] <= copro_glue_pkg::PIN_RESET_LEVEL[g];
        end
        else
        begin
          sync_first[g] <= pin_raw[g];
          sync_second[g] <= sync_first[g];
        end
      end
    end
  endgenerate

  // coprocessor reset cycle request is a pin too
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      reset_cycle_first <= 1'h0;
      reset_cycle <= 1'h0;
    end
    else
    begin
      reset_cycle_first <= I_COPRO_RESET_CYCLE;
      reset_cycle <= reset_cycle_first;
    end
  end

  // status pins float while the coprocessor is deselected, so they count only
  // when the enable was high three cycles back, in step with the synchroniser delay
  logic [2:0] enable_age;
  wire status_valid = enable_age[2];

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
      enable_age <= 3'h0;
    else
      enable_age <= {enable_age[1:0], O_COPRO_STATUS_ENABLE};
  end

  // coprocessor indications qualified by status_valid, then the unqualified channel ready and isa cycle; all active high
  wire copro_req = status_valid & sync_second[copro_glue_pkg::PIN_XFER_REQ];
  wire copro_busy = status_valid & ~sync_second[copro_glue_pkg::PIN_BUSY_N];
  wire copro_err = status_valid & ~sync_second[copro_glue_pkg::PIN_ERR_N];
  wire copro_ready = status_valid & ~sync_second[copro_glue_pkg::PIN_READY_N];
  wire chan_ready = sync_second[copro_glue_pkg::PIN_CHAN_READY];
  wire isa_cycle = sync_second[copro_glue_pkg::PIN_ISA_CYCLE];

  // internal ready sequencer: count the least ISA cycle time, then hold for
  // as long as the channel ready pin is low
  wire wait_over = (wait_cnt == copro_glue_pkg::WAIT_CNT_LAST);
  // RULE8: channel ready wait states
  wire isa_release = wait_over & chan_ready & ~reset_cycle;
  wire internal_ready = (isa_state == copro_glue_pkg::ISA_WAIT) & isa_release;

  always_comb
  begin
    next_isa_state = isa_state;
    next_wait_cnt = wait_cnt;
    case (isa_state)
      copro_glue_pkg::ISA_IDLE:
      begin
        next_wait_cnt = copro_glue_pkg::WAIT_CNT_RESET;
        if (isa_cycle)
          next_isa_state = copro_glue_pkg::ISA_WAIT;
      end
      copro_glue_pkg::ISA_WAIT:
      begin
        // a cycle that ends before release gets no ready
        if (!isa_cycle)
          next_isa_state = copro_glue_pkg::ISA_IDLE;
        else if (isa_release)
          next_isa_state = copro_glue_pkg::ISA_DONE;
        else if (!wait_over)
          next_wait_cnt = wait_cnt + 4'h1;
      end
      copro_glue_pkg::ISA_DONE:
      begin
        // one ready per cycle; wait for the cycle to end
        if (!isa_cycle)
          next_isa_state = copro_glue_pkg::ISA_IDLE;
      end
      default:
        next_isa_state = copro_glue_pkg::ISA_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      isa_state <= copro_glue_pkg::ISA_IDLE;
      wait_cnt <= copro_glue_pkg::WAIT_CNT_RESET;
    end
    else
    begin
      isa_state <= next_isa_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // the coprocessor path is a level and holds ready low while its pin is low;
  // the isa path gives a single pulse per cycle
  // RULE10: or of both readies
  wire next_host_ready_n = ~(copro_ready | internal_ready);

  // deselecting during the reset cycle keeps the floating status pins out of the relay
  // RULE7: chip select low during reset cycle
  wire next_status_enable = ~reset_cycle;

  // host-facing status outputs, registered
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      // RULE11: inactive after reset
      O_HOST_XFER_REQ_OUT <= copro_glue_pkg::XFER_REQ_RESET;
      O_HOST_BUSY_OUT_N <= copro_glue_pkg::BUSY_N_RESET;
      O_HOST_ERR_OUT_N <= copro_glue_pkg::ERR_N_RESET;
      O_COPRO_IRQ_OUT <= copro_glue_pkg::IRQ_RESET;
      O_HOST_READY_OUT_N <= copro_glue_pkg::READY_N_RESET;
      O_COPRO_STATUS_ENABLE <= copro_glue_pkg::STATUS_ENABLE_RESET;
    end
    else
    begin
      // RULE1: relay transfer request
      O_HOST_XFER_REQ_OUT <= copro_req;
      // RULE4: relay busy
      O_HOST_BUSY_OUT_N <= ~copro_busy;
      // RULE5: relay error
      O_HOST_ERR_OUT_N <= ~copro_err;
      // RULE3: interrupt from exception
      O_COPRO_IRQ_OUT <= copro_err;
      O_HOST_READY_OUT_N <= next_host_ready_n;
      O_COPRO_STATUS_ENABLE <= next_status_enable;
    end
  end

  // channel ready pin: driven low only during a coprocessor reset cycle
  // released, the pin returns to its bus pull-up and the sync sees it two edges on
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      O_CHAN_READY_OE <= copro_glue_pkg::CHAN_READY_OE_RESET;
      O_CHAN_READY_OUT <= copro_glue_pkg::CHAN_READY_OUT_RESET;
    end
    else
    begin
      // RULE9: pin turns to output
      O_CHAN_READY_OE <= reset_cycle;
      O_CHAN_READY_OUT <= 1'h0; // holds the bus in wait while driven
    end
  end

endmodule // numeric_copro_glue
`default_nettype wire

/* verif/copro_model.sv */
`timescale 1ns/100ps
`default_nettype none
module copro_model (
  input wire logic clk,
  input wire logic enable,
  input wire logic [3:0] act, // active mask: req, busy, err, ready
  output var logic req,
  output var logic busy_n,
  output var logic err_n,
  output var logic ready_n
);
  initial {req, busy_n, err_n, ready_n} = 4'h7;
  always @(posedge clk)
    if (enable) {req, busy_n, err_n, ready_n} <= {act[3], ~act[2:0]};
    else {req, busy_n, err_n, ready_n} <= ~{req, busy_n, err_n, ready_n};
endmodule // copro_model
`default_nettype wire

/* verif/numeric_copro_glue_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module numeric_copro_glue_chk (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_COPRO_XFER_REQ_IN,
  input wire logic I_COPRO_BUSY_IN_N,
  input wire logic I_COPRO_ERR_IN_N,
  input wire logic I_COPRO_READY_IN_N,
  input wire logic I_CHAN_READY_IN,
  input wire logic I_ISA_CYCLE,
  input wire logic I_COPRO_RESET_CYCLE,
  input wire logic O_HOST_XFER_REQ_OUT,
  input wire logic O_HOST_BUSY_OUT_N,
  input wire logic O_HOST_ERR_OUT_N,
  input wire logic O_COPRO_IRQ_OUT,
  input wire logic O_HOST_READY_OUT_N,
  input wire logic O_COPRO_STATUS_ENABLE,
  input wire logic O_CHAN_READY_OUT,
  input wire logic O_CHAN_READY_OE
);
  logic [3:0] en_cnt;
  wire logic en_ok = en_cnt == 4'h6; // enable settled past the mask and the syncs
  // count cycles the status enable has stood high
  always_ff @(posedge I_CLOCK)
    if (I_RESET || !O_COPRO_STATUS_ENABLE) en_cnt <= 4'h0;
    else if (!en_ok) en_cnt <= en_cnt + 4'h1;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  sequence rc_held; I_COPRO_RESET_CYCLE [*3]; endsequence
  sequence chan_wait; (!I_CHAN_READY_IN && I_COPRO_READY_IN_N) [*6]; endsequence
  a_req_relay: assert property (en_ok |-> O_HOST_XFER_REQ_OUT == $past(I_COPRO_XFER_REQ_IN, 3))
    else $error("transfer request not relayed");
  a_busy_relay: assert property (en_ok |-> O_HOST_BUSY_OUT_N == $past(I_COPRO_BUSY_IN_N, 3))
    else $error("busy not relayed");
  a_err_relay: assert property (en_ok |-> O_HOST_ERR_OUT_N == $past(I_COPRO_ERR_IN_N, 3))
    else $error("error not relayed");
  a_irq_error: assert property (O_COPRO_IRQ_OUT == !O_HOST_ERR_OUT_N)
    else $error("interrupt differs from error");
  a_reset_idle: assert property ($past(I_RESET) |-> !O_HOST_XFER_REQ_OUT && O_HOST_BUSY_OUT_N
    && O_HOST_ERR_OUT_N && !O_COPRO_IRQ_OUT) else $error("status active after reset");
  a_copro_ready: assert property (en_ok && !$past(I_COPRO_READY_IN_N, 3) |-> !O_HOST_READY_OUT_N)
    else $error("coprocessor ready not passed on");
  a_reset_cycle: assert property (rc_held |=> O_CHAN_READY_OE && !O_CHAN_READY_OUT)
    else $error("channel ready not driven in reset cycle");
  a_wait_state: assert property (chan_wait |-> O_HOST_READY_OUT_N)
    else $error("ready given during wait state");
endmodule // numeric_copro_glue_chk
bind numeric_copro_glue numeric_copro_glue_chk i_chk (.*);
`default_nettype wire

/* verif/numeric_copro_glue_test.sv */
`timescale 1ns/100ps
`default_nettype none
module numeric_copro_glue_test;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic chan_ready = 1'b1;
  logic isa_cycle = 1'b0;
  logic reset_cycle = 1'b0;
  logic [3:0] act = 4'h0;
  wire logic req, busy_n, err_n, ready_n;
  wire logic xfer_o, busy_o, err_o, irq_o, rdy_o, en_o, chan_out, chan_oe;
  wire logic chan_wire = chan_oe ? chan_out : chan_ready; // level on the shared pin
  wire logic [7:0] outs = {xfer_o, busy_o, err_o, irq_o, rdy_o, en_o, chan_oe, chan_out};
  int n_fail = 0;
  int checked = 0;
  always #5 clock = ~clock;
  copro_model i_copro_model (.clk(clock), .enable(en_o), .act(act), .req(req),
    .busy_n(busy_n), .err_n(err_n), .ready_n(ready_n));
  numeric_copro_glue i_numeric_copro_glue (.I_CLOCK(clock), .I_RESET(reset),
    .I_COPRO_XFER_REQ_IN(req), .I_COPRO_BUSY_IN_N(busy_n), .I_COPRO_ERR_IN_N(err_n),
    .I_COPRO_READY_IN_N(ready_n), .I_CHAN_READY_IN(chan_wire), .I_ISA_CYCLE(isa_cycle),
    .I_COPRO_RESET_CYCLE(reset_cycle), .O_HOST_XFER_REQ_OUT(xfer_o), .O_HOST_BUSY_OUT_N(busy_o),
    .O_HOST_ERR_OUT_N(err_o), .O_COPRO_IRQ_OUT(irq_o), .O_HOST_READY_OUT_N(rdy_o),
    .O_COPRO_STATUS_ENABLE(en_o), .O_CHAN_READY_OUT(chan_out), .O_CHAN_READY_OE(chan_oe));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // wait for the isa ready pulse, then end the cycle
  task automatic isa_wait(output int lat);
    lat = 0;
    while (rdy_o !== 1'b0 && lat < 40)
    begin
      cyc(1);
      lat++;
    end
    cyc(1);
    chk({7'h0, rdy_o}, 8'h01);
    isa_cycle <= 1'b0;
    cyc(6);
  endtask
  task automatic t_reset;
    reset <= 1'b1;
    cyc(6);
    chk(outs, 8'h68);
    reset <= 1'b0;
    cyc(2);
    chk(outs, 8'h6c);
    $display("reset test done");
  endtask
  task automatic t_relay;
    logic [3:0] a;
    for (int i = 0; i < 5; i++)
    begin
      a = (i < 4) ? 4'h1 << i : 4'h0;
      act <= a;
      cyc(8);
      chk(outs, {a[3], ~a[2], ~a[1], a[1], ~a[0], 3'b100});
    end
    $display("relay test done");
  endtask
  task automatic t_isa;
    int lat;
    isa_cycle <= 1'b1;
    isa_wait(lat);
    // two sync stages, the counted minimum (wait entry included) and the output register
    chk(8'(lat), 8'(copro_glue_pkg::ISA_MIN_CYCLES + 3));
    $display("isa test done");
  endtask
  task automatic t_wait;
    int lat;
    chan_ready <= 1'b0;
    isa_cycle <= 1'b1;
    cyc(12);
    chk({7'h0, rdy_o}, 8'h01);
    chan_ready <= 1'b1;
    isa_wait(lat);
    // ready follows the channel ready pin after two sync stages and the output register
    chk(8'(lat), 8'h03);
    $display("wait test done");
  endtask
  task automatic t_rcycle;
    reset_cycle <= 1'b1;
    cyc(8);
    chk(outs, 8'h6a);
    reset_cycle <= 1'b0;
    cyc(12);
    chk(outs, 8'h6c);
    $display("reset cycle test done");
  endtask
  // reset in mid-run while busy and error stand active
  task automatic t_midreset;
    act <= 4'h6;
    cyc(8);
    chk(outs, 8'h1c);
    t_reset;
    act <= 4'h0;
    $display("mid-run reset test done");
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (3000) @(posedge clock);
    n_fail++;
    test_done;
  end
  // test sequence
  initial
  begin
    t_reset;
    t_relay;
    t_isa;
    t_wait;
    t_rcycle;
    t_midreset;
    test_done;
  end
endmodule // numeric_copro_glue_test
`default_nettype wire
